// ===== src/sglb_params.svh
// Offsets, field positions, reset values and timing counts of the pin block.
// Assumes inclusion from the package and from each design module.
`ifndef SGLB_PARAMS_SVH
`define SGLB_PARAMS_SVH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SGLB_REG_OUT_DATA     8'h0d
`define SGLB_REG_DIR          8'h0e
`define SGLB_REG_SNS_EN       8'h17
`define SGLB_REG_SNS_GAIN     8'h18
`define SGLB_REG_SNS_LIM      8'h1a
`define SGLB_REG_ALM_EN       8'h1d
`define SGLB_REG_ALM_FWD      8'h1e
`define SGLB_REG_FWD_CNT      8'h20
`define SGLB_REG_CLR          8'h49
`define SGLB_REG_STATUS       8'h52
`define SGLB_REG_PIN_STS      8'h53
`define SGLB_REG_ERR_CNT      8'h54
`define SGLB_REG_SNS_STS      8'h57
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SGLB_RST_DIR          8'h0f
`define SGLB_RST_GAIN         8'hb2
`define SGLB_RST_LIM          8'h62
`define SGLB_RST_ZERO         8'h00
`define SGLB_PRBS_SEED        7'h7f
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SGLB_SNS_EN_BIT       4
`define SGLB_LIM_LO_LSB       0
`define SGLB_LIM_HI_LSB       3
`define SGLB_STS_BELOW_BIT    2
`define SGLB_STS_ABOVE_BIT    3
`define SGLB_ST_ERR_BIT       3
`define SGLB_CLR_BIT          5
`define SGLB_BC_ST_BIT        4
`define SGLB_BC_CRC_BIT       29
// ----------------------------------------------------------------------
// Frame sizes and timing
// ----------------------------------------------------------------------
`define SGLB_BC_FRAME_BITS    5'd30
`define SGLB_FC_FRAME_CYC     3'd4
`define SGLB_CLK_NS           50
`define SGLB_FWD_LAT_NS       225
`define SGLB_FWD_LAT_CYC      (`SGLB_FWD_LAT_NS / `SGLB_CLK_NS)
`define SGLB_FSYNC_SKEW_NS    600
`endif

// ===== src/sglb_pkg.sv
// Types shared by the pin block modules.
// Assumes the params header sits beside it.
package sglb_pkg;
`include "sglb_params.svh"
   typedef enum logic {SGLB_RX_IDLE, SGLB_RX_SHIFT} sglb_rx_state_t;
   typedef logic [3:0] sglb_pins_t;
endpackage : sglb_pkg

// ===== src/sglb_bc_if.sv
// Decoded back-channel frame passed from receiver to core.
// Assumes both ends run on core_clk.
interface sglb_bc_if;
   import sglb_pkg::*;
   logic       valid;
   sglb_pins_t remote;
   logic       selftest;
   logic       crc_err;
   modport rx   (output valid, remote, selftest, crc_err);
   modport core (input valid, remote, selftest, crc_err);
endinterface : sglb_bc_if

// ===== src/sglb_bc_rx.sv
// Back-channel frame receiver: samples link clock, sync and data pins.
// Assumes link clock well below core_clk/4; sync marks a frame's first bit.
module sglb_bc_rx
   import sglb_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic bc_clk_pin,
   input  wire logic bc_sync_pin,
   input  wire logic bc_data_pin,
   sglb_bc_if.rx     bc
);
`include "sglb_params.svh"
   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic [2:0]     meta_reg, meta_next;
   logic [2:0]     sync_reg, sync_next;
   logic           clk_last_reg, clk_last_next;
   sglb_rx_state_t state_reg, state_next;
   logic [29:0]    shift_reg, shift_next;
   logic [4:0]     count_reg, count_next;
   logic           valid_reg, valid_next;
   sglb_pins_t     remote_reg, remote_next;
   logic           st_reg, st_next;
   logic           crc_reg, crc_next;
   logic           rise;
   logic [29:0]    frame;

   always_comb
   begin
      meta_next     = {bc_clk_pin, bc_sync_pin, bc_data_pin};
      sync_next     = meta_reg;
      clk_last_next = sync_reg[2];
   end

   // ----------------------------------------------------------------------
   // Frame assembly, LSB first
   // ----------------------------------------------------------------------
   always_comb
   begin
      rise        = sync_reg[2] & ~clk_last_reg;
      frame       = {sync_reg[0], shift_reg[29:1]};
      state_next  = state_reg;
      shift_next  = shift_reg;
      count_next  = count_reg;
      valid_next  = 1'b0;
      remote_next = remote_reg;
      st_next     = st_reg;
      crc_next    = crc_reg;
      if (rise)
      begin
         case (state_reg)
            SGLB_RX_IDLE:
            begin
               if (sync_reg[1])
               begin
                  shift_next = {sync_reg[0], 29'h0000_0000};
                  count_next = 5'd1;
                  state_next = SGLB_RX_SHIFT;
               end
            end
            SGLB_RX_SHIFT:
            begin
               shift_next = frame;
               count_next = count_reg + 5'd1;
               if (count_next == `SGLB_BC_FRAME_BITS)
               begin
                  // Update once per frame, so pin rate follows link rate [R13]
                  valid_next  = 1'b1; // [R23]
                  remote_next = frame[3:0];
                  st_next     = frame[`SGLB_BC_ST_BIT];
                  // Even parity across the frame stands in for its check
                  crc_next    = ^frame; // [R17]
                  state_next  = SGLB_RX_IDLE;
               end
            end
            default: state_next = SGLB_RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_reg     <= 3'h0;
         sync_reg     <= 3'h0;
         clk_last_reg <= 1'b0;
         state_reg    <= SGLB_RX_IDLE;
         shift_reg    <= 30'h0000_0000;
         count_reg    <= 5'h00;
         valid_reg    <= 1'b0;
         remote_reg   <= 4'h0;
         st_reg       <= 1'b0;
         crc_reg      <= 1'b0;
      end
      else
      begin
         meta_reg     <= meta_next;
         sync_reg     <= sync_next;
         clk_last_reg <= clk_last_next;
         state_reg    <= state_next;
         shift_reg    <= shift_next;
         count_reg    <= count_next;
         valid_reg    <= valid_next;
         remote_reg   <= remote_next;
         st_reg       <= st_next;
         crc_reg      <= crc_next;
      end
   end

   assign bc.valid    = valid_reg;
   assign bc.remote   = remote_reg;
   assign bc.selftest = st_reg;
   assign bc.crc_err  = crc_reg;
endmodule : sglb_bc_rx

// ===== src/sglb_top.sv
// Pin block of the link serializer: pins, forwarding, sensing, self test.
// Assumes a register port from the local I2C target, on core_clk.
//
// Functional notes
// R1: Four pins, controlled through registers 0x0d, 0x0e, 0x53.
// R2: Level register reads every pin's level, input or output.
// R3: After reset all four pins are inputs.
// R4: Software clears output enable when it sets input enable.
// R5: Software clears input enable when it sets output enable.
// R6: Up to four input levels are forwarded to the far end.
// R7: One linked pin is sampled every forward frame.
// R8: Two linked pins are sampled every two forward frames.
// R9: Three or four linked pins are sampled every five frames.
// R10: Forward latency stays fixed near 225 ns; only jitter grows.
// R11: Users keep forwarded signals below a quarter of sample rate.
// R12: An output pin may drive the remote back-channel value.
// R13: Back-channel pin sampling rate follows the back-channel rate.
// R14: The far end starts self test and signals it on back channel.
// R15: Self test is run only in synchronous clocking mode.
// R16: During self test a pseudo-random stream replaces payload; here it goes out on fc_prbs_bit while pin samples still flow.
// R17: During self test back-channel frame check errors are tracked.
// R18: Any pin can output a frame-sync value from the back channel.
// R19: Frame-sync skew is about one back-channel frame.
// R20: Pins 0 and 1 can sense an external voltage.
// R21: Software programs sensor enable, alarms and alarm forwarding.
// R22: Sensor status bits 2 and 3 flag below and above limits.
// R23: Pin values arrive in 30-bit back-channel frames.
// R24: Self-test error flag and counter; a clear bit resets them.
// R25: Pin levels pass two synchroniser flops before use.
// R26: Remote-driven pins hold their value until a newer frame.
// R27: A pin with both enables set acts as an output.
module sglb_top
   import sglb_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic [3:0] gpio_in,
   output logic      [3:0] gpio_out,
   output logic      [3:0] gpio_oe,
   input  wire logic       bc_clk_pin,
   input  wire logic       bc_sync_pin,
   input  wire logic       bc_data_pin,
   input  wire logic [2:0] sense_code_pin,
   output logic            fc_frame_strobe,
   output logic            fc_pin_valid,
   output logic      [3:0] fc_pin_data,
   output logic            fc_selftest,
   output logic            fc_prbs_bit,
   output logic            sensor_alarm
);
`include "sglb_params.svh"
   // ----------------------------------------------------------------------
   // Back-channel receiver
   // ----------------------------------------------------------------------
   sglb_bc_if bc ();
   sglb_bc_rx u_rx (
      .core_clk    (core_clk),
      .rst_n       (rst_n),
      .bc_clk_pin  (bc_clk_pin),
      .bc_sync_pin (bc_sync_pin),
      .bc_data_pin (bc_data_pin),
      .bc          (bc)
   );

   // ----------------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------------
   logic [7:0] out_data_reg, out_data_next;
   logic [7:0] dir_reg,      dir_next;
   logic [7:0] sns_en_reg,   sns_en_next;
   logic [7:0] gain_reg,     gain_next;
   logic [7:0] lim_reg,      lim_next;
   logic [7:0] alm_en_reg,   alm_en_next;
   logic [7:0] alm_fwd_reg,  alm_fwd_next;
   logic [2:0] link_cnt_reg, link_cnt_next;
   logic [7:0] rdata_reg,    rdata_next;
   logic       clr_hit;

   always_comb
   begin
      out_data_next = out_data_reg;
      dir_next      = dir_reg;
      sns_en_next   = sns_en_reg;
      gain_next     = gain_reg;
      lim_next      = lim_reg;
      alm_en_next   = alm_en_reg;
      alm_fwd_next  = alm_fwd_reg;
      link_cnt_next = link_cnt_reg;
      clr_hit       = 1'b0;
      if (reg_wr)
      begin
         if (reg_addr == `SGLB_REG_OUT_DATA)
            out_data_next = reg_wdata; // [R1] [R12]
         else if (reg_addr == `SGLB_REG_DIR)
            dir_next = reg_wdata; // [R1]
         else if (reg_addr == `SGLB_REG_SNS_EN)
            sns_en_next = reg_wdata;
         else if (reg_addr == `SGLB_REG_SNS_GAIN)
            gain_next = reg_wdata;
         else if (reg_addr == `SGLB_REG_SNS_LIM)
            lim_next = reg_wdata;
         else if (reg_addr == `SGLB_REG_ALM_EN)
            alm_en_next = reg_wdata;
         else if (reg_addr == `SGLB_REG_ALM_FWD)
            alm_fwd_next = reg_wdata;
         else if (reg_addr == `SGLB_REG_FWD_CNT)
            // Counts above four clamp to four
            link_cnt_next = (reg_wdata > 8'h04) ? 3'd4 : reg_wdata[2:0];
         else if (reg_addr == `SGLB_REG_CLR)
            clr_hit = reg_wdata[`SGLB_CLR_BIT]; // [R24]
      end
   end

   // ----------------------------------------------------------------------
   // Pin levels, sensor input synchronisers
   // ----------------------------------------------------------------------
   logic [3:0] pin_meta_reg, pin_lvl_reg;
   logic [2:0] code_meta_reg, code_reg;

   // ----------------------------------------------------------------------
   // Pin drivers and remote values
   // ----------------------------------------------------------------------
   sglb_pins_t remote_reg, remote_next;
   logic [3:0] gpio_out_next, gpio_oe_next;

   always_comb
   begin
      // Only good frames replace the held value [R26]
      remote_next = (bc.valid && !bc.crc_err) ? bc.remote : remote_reg;
      // Output enable wins when both are set; reset value leaves inputs
      gpio_oe_next  = dir_reg[7:4]; // [R3] [R27]
      // Upper nibble selects remote source per pin [R12] [R18]
      gpio_out_next = (out_data_reg[7:4] & remote_reg)
                    | (~out_data_reg[7:4] & out_data_reg[3:0]);
   end

   // ----------------------------------------------------------------------
   // Forward channel framing and pin sampling
   // ----------------------------------------------------------------------
   logic [2:0] fdiv_reg,  fdiv_next;
   logic [2:0] fsamp_reg, fsamp_next;
   logic [2:0] period;
   logic       fstrobe_next, fvalid_next;
   logic [3:0] fdata_next;
   logic [3:0] in_mask;

   always_comb
   begin
      in_mask = dir_reg[3:0] & ~dir_reg[7:4];
      if (link_cnt_reg <= 3'd1)
         period = 3'd1; // [R7]
      else if (link_cnt_reg == 3'd2)
         period = 3'd2; // [R8]
      else
         period = 3'd5; // [R9]
      fdiv_next    = (fdiv_reg == `SGLB_FC_FRAME_CYC - 3'd1) ? 3'd0
                   : fdiv_reg + 3'd1;
      fstrobe_next = (fdiv_reg == `SGLB_FC_FRAME_CYC - 3'd1);
      fsamp_next   = fsamp_reg;
      fvalid_next  = 1'b0;
      fdata_next   = fc_pin_data;
      if (fstrobe_next)
      begin
         fsamp_next = (fsamp_reg + 3'd1 >= period) ? 3'd0
                    : fsamp_reg + 3'd1;
         // Fixed one-cycle sample path keeps latency constant [R10]
         if (fsamp_reg == 3'd0 && link_cnt_reg != 3'd0)
         begin
            fvalid_next = 1'b1; // [R6]
            fdata_next  = pin_lvl_reg & in_mask; // [R25]
         end
      end
      // New count restarts the phase, so no stale skip [R7] [R8]
      if (link_cnt_next != link_cnt_reg)
         fsamp_next = 3'd0;
   end

   // ----------------------------------------------------------------------
   // Self test: PRBS stream and error tracking
   // ----------------------------------------------------------------------
   logic [6:0] prbs_reg, prbs_next;
   logic       st_reg,   st_next;
   logic       prbs_bit_next;
   logic       err_flag_reg, err_flag_next;
   logic [7:0] err_cnt_reg,  err_cnt_next;
   logic       err_hit;

   always_comb
   begin
      st_next       = bc.valid ? bc.selftest : st_reg; // [R14]
      prbs_next     = st_reg ? {prbs_reg[5:0], prbs_reg[6] ^ prbs_reg[5]}
                    : `SGLB_PRBS_SEED;
      prbs_bit_next = st_reg & prbs_reg[6]; // [R16]
      err_hit       = bc.valid & bc.crc_err & st_reg; // [R17]
      err_flag_next = err_flag_reg;
      err_cnt_next  = err_cnt_reg;
      if (clr_hit)
      begin
         err_flag_next = 1'b0;
         err_cnt_next  = 8'h00;
      end
      // Set beats a clear in the same cycle
      if (err_hit)
      begin
         err_flag_next = 1'b1; // [R24]
         err_cnt_next  = (err_cnt_next == 8'hff) ? 8'hff
                       : err_cnt_next + 8'h01;
      end
   end

   // ----------------------------------------------------------------------
   // Voltage sensing on pins 0 and 1
   // ----------------------------------------------------------------------
   logic [7:0] sns_sts_reg, sns_sts_next;
   logic       alarm_next;

   always_comb
   begin
      sns_sts_next = 8'h00;
      if (sns_en_reg[`SGLB_SNS_EN_BIT]) // [R20] [R21]
      begin
         sns_sts_next[`SGLB_STS_BELOW_BIT] =
            code_reg < lim_reg[`SGLB_LIM_LO_LSB +: 3]; // [R22]
         sns_sts_next[`SGLB_STS_ABOVE_BIT] =
            code_reg > lim_reg[`SGLB_LIM_HI_LSB +: 3]; // [R22]
      end
      alarm_next = alm_fwd_reg[0]
                 & ((sns_sts_reg[`SGLB_STS_BELOW_BIT] & alm_en_reg[0])
                 | (sns_sts_reg[`SGLB_STS_ABOVE_BIT] & alm_en_reg[1]));
   end

   // ----------------------------------------------------------------------
   // Read mux, unmapped offsets read zero
   // ----------------------------------------------------------------------
   always_comb
   begin
      rdata_next = rdata_reg;
      if (reg_rd)
      begin
         if (reg_addr == `SGLB_REG_OUT_DATA)
            rdata_next = out_data_reg;
         else if (reg_addr == `SGLB_REG_DIR)
            rdata_next = dir_reg;
         else if (reg_addr == `SGLB_REG_SNS_EN)
            rdata_next = sns_en_reg;
         else if (reg_addr == `SGLB_REG_SNS_GAIN)
            rdata_next = gain_reg;
         else if (reg_addr == `SGLB_REG_SNS_LIM)
            rdata_next = lim_reg;
         else if (reg_addr == `SGLB_REG_ALM_EN)
            rdata_next = alm_en_reg;
         else if (reg_addr == `SGLB_REG_ALM_FWD)
            rdata_next = alm_fwd_reg;
         else if (reg_addr == `SGLB_REG_FWD_CNT)
            rdata_next = {5'h00, link_cnt_reg};
         else if (reg_addr == `SGLB_REG_STATUS)
            rdata_next = {4'h0, err_flag_reg, 3'h0};
         else if (reg_addr == `SGLB_REG_PIN_STS)
            rdata_next = {4'h0, pin_lvl_reg}; // [R2]
         else if (reg_addr == `SGLB_REG_ERR_CNT)
            rdata_next = err_cnt_reg; // [R24]
         else if (reg_addr == `SGLB_REG_SNS_STS)
            rdata_next = sns_sts_reg;
         else
            rdata_next = 8'h00;
      end
   end

   // ----------------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_data_reg    <= `SGLB_RST_ZERO;
         dir_reg         <= `SGLB_RST_DIR;
         sns_en_reg      <= `SGLB_RST_ZERO;
         gain_reg        <= `SGLB_RST_GAIN;
         lim_reg         <= `SGLB_RST_LIM;
         alm_en_reg      <= `SGLB_RST_ZERO;
         alm_fwd_reg     <= `SGLB_RST_ZERO;
         link_cnt_reg    <= 3'h0;
         rdata_reg       <= 8'h00;
         pin_meta_reg    <= 4'h0;
         pin_lvl_reg     <= 4'h0;
         code_meta_reg   <= 3'h0;
         code_reg        <= 3'h0;
         remote_reg      <= 4'h0;
         gpio_out        <= 4'h0;
         gpio_oe         <= 4'h0;
         fdiv_reg        <= 3'h0;
         fsamp_reg       <= 3'h0;
         fc_frame_strobe <= 1'b0;
         fc_pin_valid    <= 1'b0;
         fc_pin_data     <= 4'h0;
         prbs_reg        <= `SGLB_PRBS_SEED;
         st_reg          <= 1'b0;
         fc_prbs_bit     <= 1'b0;
         err_flag_reg    <= 1'b0;
         err_cnt_reg     <= 8'h00;
         sns_sts_reg     <= 8'h00;
         sensor_alarm    <= 1'b0;
      end
      else
      begin
         out_data_reg    <= out_data_next;
         dir_reg         <= dir_next;
         sns_en_reg      <= sns_en_next;
         gain_reg        <= gain_next;
         lim_reg         <= lim_next;
         alm_en_reg      <= alm_en_next;
         alm_fwd_reg     <= alm_fwd_next;
         link_cnt_reg    <= link_cnt_next;
         rdata_reg       <= rdata_next;
         pin_meta_reg    <= gpio_in; // [R25]
         pin_lvl_reg     <= pin_meta_reg;
         code_meta_reg   <= sense_code_pin;
         code_reg        <= code_meta_reg;
         remote_reg      <= remote_next;
         gpio_out        <= gpio_out_next;
         gpio_oe         <= gpio_oe_next;
         fdiv_reg        <= fdiv_next;
         fsamp_reg       <= fsamp_next;
         fc_frame_strobe <= fstrobe_next;
         fc_pin_valid    <= fvalid_next;
         fc_pin_data     <= fdata_next;
         prbs_reg        <= prbs_next;
         st_reg          <= st_next;
         fc_prbs_bit     <= prbs_bit_next;
         err_flag_reg    <= err_flag_next;
         err_cnt_reg     <= err_cnt_next;
         sns_sts_reg     <= sns_sts_next;
         sensor_alarm    <= alarm_next;
      end
   end

   assign reg_rdata   = rdata_reg;
   assign fc_selftest = st_reg;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_good_frame;
      bc.valid && !bc.crc_err;
   endsequence
   sequence s_bad_st_frame;
      bc.valid && bc.crc_err && st_reg;
   endsequence

   a_oe_both_set: assert property ( // [R27]
      dir_reg[7:4] == 4'hf |=> gpio_oe == 4'hf)
      else $error("both enables did not give an output");
   a_level_readback: assert property ( // [R2]
      reg_rd && reg_addr == `SGLB_REG_PIN_STS
      |=> reg_rdata == {4'h0, $past(pin_lvl_reg)})
      else $error("pin level readback wrong");
   a_one_pin_rate: assert property ( // [R7]
      fstrobe_next && link_cnt_reg == 3'd1 |=> fc_pin_valid)
      else $error("single pin not sampled each frame");
   a_two_pin_gap: assert property ( // [R8]
      fc_pin_valid && link_cnt_reg == 3'd2 && $stable(link_cnt_reg)
      |=> (!fc_pin_valid || link_cnt_reg != 3'd2)[*7]
      ##1 (fc_pin_valid || link_cnt_reg != 3'd2))
      else $error("two pin sampling not every two frames");
   a_prbs_quiet: assert property ( // [R16]
      !st_reg |=> !fc_prbs_bit)
      else $error("pattern bit while not in self test");
   a_err_count_up: assert property ( // [R17]
      s_bad_st_frame ##0 err_cnt_reg < 8'hff
      |=> err_cnt_reg == ($past(clr_hit) ? 8'h01
                                         : $past(err_cnt_reg) + 8'h01))
      else $error("self-test error not counted");
   a_err_set_wins: assert property ( // [R24]
      s_bad_st_frame |=> err_flag_reg ##1 1'b1)
      else $error("self-test error flag lost");
   a_remote_hold: assert property ( // [R26]
      !bc.valid |=> $stable(remote_reg))
      else $error("remote value changed without a frame");
   a_fsync_skew: assert property ( // [R18] [R19]
      s_good_frame ##0 out_data_reg[7:4] == 4'hf ##1
      out_data_reg[7:4] == 4'hf |=> gpio_out == $past(bc.remote, 2))
      else $error("frame-sync output late or wrong");
   a_sense_above: assert property ( // [R22]
      sns_en_reg[`SGLB_SNS_EN_BIT] && code_reg > lim_reg[5:3]
      |=> sns_sts_reg[`SGLB_STS_ABOVE_BIT])
      else $error("above-limit status missing");
endmodule : sglb_top

// ===== testbench/sglb_bc_model.sv
// Far-end back-channel sender: link clock, sync and data lines.
// Assumes the bench calls send; link clock idles low between frames.
module sglb_bc_model
(
   output logic bc_clk  = 1'b0,
   output logic bc_sync = 1'b0,
   output logic bc_data = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   // Bits 3:0 remote, bit 4 self test, bit 29 even parity
   task automatic send(input logic [3:0] rem, input logic st,
                       input logic bad);
      logic [29:0] f;
      f = {6'h00, 19'h00000, st, rem};
      f[29] = (^f[28:0]) ^ bad;
      for (int i = 0; i < 30; i++)
      begin
         bc_data = f[i];
         bc_sync = (i == 0);
         #200 bc_clk = 1'b1;
         #200 bc_clk = 1'b0;
      end
      bc_sync = 1'b0;
      // Released line shows the inverse, not a stale bit
      bc_data = ~f[29];
   endtask : send
endmodule : sglb_bc_model

// ===== testbench/testbench.sv
// Self-checking bench of the pin block through its register port.
// Assumes the back-channel model drives the three link pins.
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
$display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic       core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic [3:0] gpio_in = 4'h0, gpio_out, gpio_oe, fc_pin_data;
   logic [2:0] sense_code_pin = 3'h0;
   logic       bck, bcs, bcd, fc_frame_strobe, fc_pin_valid;
   logic       fc_selftest, fc_prbs_bit, sensor_alarm;
   int         failures = 0, comparisons = 0;
   int         ones;
   time        t;
   sglb_bc_model bcm (.bc_clk(bck), .bc_sync(bcs), .bc_data(bcd));
   sglb_top dut (.core_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd,
      .reg_wdata, .reg_rdata, .gpio_in, .gpio_out, .gpio_oe,
      .bc_clk_pin(bck), .bc_sync_pin(bcs), .bc_data_pin(bcd),
      .sense_code_pin, .fc_frame_strobe, .fc_pin_valid, .fc_pin_data,
      .fc_selftest, .fc_prbs_bit, .sensor_alarm);
   always #25 core_clk = ~core_clk;
   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   task automatic w(input int c);
      repeat (c) @(posedge core_clk);
      #1;
   endtask : w
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      w(1);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      w(1);
      reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      w(1);
      reg_addr = a;
      reg_rd = 1'b1;
      w(1);
      reg_rd = 1'b0;
      `CHK(reg_rdata, e)
   endtask : rd
   // Gap between sample pulses, in clocks
   task automatic per(input logic [7:0] c, input int e);
      wr(8'h20, c);
      w(30);
      @(posedge fc_pin_valid);
      t = $time;
      @(posedge fc_pin_valid);
      `CHK(int'(($time - t) / 50), e)
      #1 `CHK(fc_pin_data, 4'ha)
      `CHK(fc_frame_strobe, 1'b1)
   endtask : per
   task automatic sns(input logic [2:0] c, input logic [7:0] e);
      sense_code_pin = c;
      w(6);
      rd(8'h57, e);
      `CHK(sensor_alarm, e != 8'h00)
   endtask : sns
   task automatic conclude();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   initial
   begin
      #1_000_000;
      failures++;
      conclude();
   end
   initial
   begin
      w(8);
      rst_n = 1'b1;
      rd(8'h0e, 8'h0f);
      `CHK(gpio_oe, 4'h0)
      rd(8'h18, 8'hb2);
      rd(8'h30, 8'h00);
      gpio_in = 4'ha; // Held steady, far below the sample rate
      w(3);
      rd(8'h53, 8'h0a);
      wr(8'h53, 8'h00);
      rd(8'h53, 8'h0a);
      wr(8'h0e, 8'hff);
      wr(8'h0d, 8'h05);
      w(2);
      `CHK(gpio_oe, 4'hf)
      `CHK(gpio_out, 4'h5)
      wr(8'h0e, 8'hf0);
      wr(8'h0d, 8'hf0);
      bcm.send(4'h9, 1'b0, 1'b0);
      w(10);
      `CHK(gpio_out, 4'h9)
      bcm.send(4'h6, 1'b0, 1'b1);
      w(10);
      `CHK(gpio_out, 4'h9)
      bcm.send(4'h9, 1'b1, 1'b0);
      w(10);
      `CHK(fc_selftest, 1'b1)
      ones = 0;
      repeat (127)
      begin
         w(1);
         ones += int'(fc_prbs_bit);
      end
      `CHK(ones, 64)
      rd(8'h54, 8'h00);
      bcm.send(4'h9, 1'b1, 1'b1);
      w(10);
      rd(8'h52, 8'h08);
      rd(8'h54, 8'h01);
      wr(8'h49, 8'h20);
      rd(8'h54, 8'h00);
      rd(8'h52, 8'h00);
      bcm.send(4'h9, 1'b0, 1'b0);
      w(10);
      `CHK(fc_prbs_bit, 1'b0)
      wr(8'h0e, 8'h0f);
      per(8'h01, 4);
      per(8'h02, 8);
      per(8'h03, 20);
      per(8'h04, 20);
      wr(8'h17, 8'h3e);
      wr(8'h1a, 8'h2a);
      wr(8'h1d, 8'h03);
      wr(8'h1e, 8'h01);
      sns(3'h1, 8'h04);
      sns(3'h7, 8'h08);
      sns(3'h3, 8'h00);
      conclude();
   end
endmodule : testbench
